// ===== hw/amcr_pkg.sv
/*
  Package for the converter miscellaneous configuration register bank.
  Holds register offsets, field positions, reset values and carrier types.
  Assumes an 8-bit register port with byte addresses, as the serial port
  presents it after decoding.
*/
// Overview of operation
// - Read-only 24-bit sync edge position, resets zero.
// - Four-bit delay select chooses capture delay.
// - Sixteen-bit full-scale trim, reset 0xA000, all channels.
// - Power profile resets 0x4B; 0x46 low power.
// - Timestamp control bit zero enables input receiver.
// - Reference output driven only with both enables.
// - Reference output enable bit resets to one.
package amcr_pkg;

  // ==========================================================================
  // Byte addresses of the registers.
  // ==========================================================================
  localparam logic [7:0] AMCR_SEL_ADDR = 8'h29;
  localparam logic [7:0] AMCR_POS_ADDR0 = 8'h2C;
  localparam logic [7:0] AMCR_POS_ADDR1 = 8'h2D;
  localparam logic [7:0] AMCR_POS_ADDR2 = 8'h2E;
  localparam logic [7:0] AMCR_FS_ADDR0 = 8'h30;
  localparam logic [7:0] AMCR_FS_ADDR1 = 8'h31;
  localparam logic [7:0] AMCR_PWR_ADDR = 8'h37;
  localparam logic [7:0] AMCR_TS_ADDR = 8'h3B;
  localparam logic [7:0] AMCR_REFO_ADDR = 8'h3C;

  // ==========================================================================
  // Field positions and reset values.
  // ==========================================================================
  localparam int AMCR_SEL_W = 4;
  localparam int AMCR_TS_EN_BIT = 0;
  localparam int AMCR_TS_PECL_BIT = 1;
  localparam int AMCR_REFO_EN_BIT = 0;
  localparam logic [23:0] AMCR_POS_RST = 24'h000000;
  localparam logic [15:0] AMCR_FS_RST = 16'hA000;
  localparam logic [7:0] AMCR_PWR_RST = 8'h4B;
  localparam logic [7:0] AMCR_PWR_LOW = 8'h46;
  localparam logic [7:0] AMCR_TS_RST = 8'h00;
  localparam logic [7:0] AMCR_REFO_RST = 8'h01;
  localparam logic [3:0] AMCR_SEL_RST = 4'h0;

  // ==========================================================================
  // Carrier types.
  // ==========================================================================
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amcr_req_t;

  typedef struct packed {
    logic [3:0] sync_delay_select;
    logic [15:0] full_scale_trim;
    logic [7:0] power_profile_code;
    logic low_power_mode;
    logic timestamp_input_enable;
    logic timestamp_input_pecl_mode;
    logic ref_clock_output;
  } amcr_ctl_t;

endpackage : amcr_pkg

// ===== hw/amcr_regs.sv
/*
  Register bank for sync position status, full-scale trim, power profile,
  timestamp input control and reference clock output control.
  Assumes the serial port front end hands over one decoded byte access per
  strobe, synchronous to clk_sys, and that position capture comes from the
  sync edge detector as a 24-bit word with a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module amcr_regs
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Register access port.
  input wire amcr_pkg::amcr_req_t req,
  output var logic [7:0] rdata,
  output var logic rvalid,
  // Edge position capture.
  input wire logic pos_capture,
  input wire logic [23:0] pos_value,
  // Synthesizer state.
  input wire logic synth_enable,
  // Control outputs.
  output var amcr_pkg::amcr_ctl_t ctl
);
  import amcr_pkg::*;

  // ==========================================================================
  // Storage.
  // ==========================================================================
  logic [23:0] sync_edge_position;
  logic [15:0] full_scale_trim;
  logic [7:0] power_profile_one;
  logic [7:0] timestamp_input_control;
  logic [7:0] ref_clock_output_control;
  logic [AMCR_SEL_W-1:0] sync_delay_select;

  wire wr_sel = req.wr && req.addr == AMCR_SEL_ADDR;
  wire wr_fs0 = req.wr && req.addr == AMCR_FS_ADDR0;
  wire wr_fs1 = req.wr && req.addr == AMCR_FS_ADDR1;
  wire wr_pwr = req.wr && req.addr == AMCR_PWR_ADDR;
  wire wr_ts = req.wr && req.addr == AMCR_TS_ADDR;
  wire wr_refo = req.wr && req.addr == AMCR_REFO_ADDR;

  // ==========================================================================
  // Read selection. Unmapped addresses read as zero.
  // ==========================================================================
  logic [7:0] next_rdata;
  always_comb
  begin
    case (req.addr)
      AMCR_SEL_ADDR: next_rdata = {4'h0, sync_delay_select};
      AMCR_POS_ADDR0: next_rdata = sync_edge_position[7:0];
      AMCR_POS_ADDR1: next_rdata = sync_edge_position[15:8];
      AMCR_POS_ADDR2: next_rdata = sync_edge_position[23:16];
      AMCR_FS_ADDR0: next_rdata = full_scale_trim[7:0];
      AMCR_FS_ADDR1: next_rdata = full_scale_trim[15:8];
      AMCR_PWR_ADDR: next_rdata = power_profile_one;
      AMCR_TS_ADDR: next_rdata = timestamp_input_control;
      AMCR_REFO_ADDR: next_rdata = ref_clock_output_control;
      default: next_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Registers.
  // ==========================================================================
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync_edge_position <= AMCR_POS_RST;
      full_scale_trim <= AMCR_FS_RST;
      power_profile_one <= AMCR_PWR_RST;
      timestamp_input_control <= AMCR_TS_RST;
      ref_clock_output_control <= AMCR_REFO_RST;
      sync_delay_select <= AMCR_SEL_RST;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      if (pos_capture)
        sync_edge_position <= pos_value;
      if (wr_sel)
        sync_delay_select <= req.wdata[AMCR_SEL_W-1:0];
      if (wr_fs0)
        full_scale_trim[7:0] <= req.wdata;
      if (wr_fs1)
        full_scale_trim[15:8] <= req.wdata;
      if (wr_pwr)
        power_profile_one <= req.wdata;
      // Reserved bits store what is written, so the host reads back its own
      // value; keeping them at reset is the host's duty.
      if (wr_ts)
        timestamp_input_control <= req.wdata;
      if (wr_refo)
        ref_clock_output_control <= req.wdata;
      rdata <= req.rd ? next_rdata : 8'h00;
      rvalid <= req.rd;
    end
  end

  // ==========================================================================
  // Control outputs, registered.
  // ==========================================================================
  amcr_ctl_t next_ctl;
  always_comb
  begin
    next_ctl.sync_delay_select = sync_delay_select;
    next_ctl.full_scale_trim = full_scale_trim;
    next_ctl.power_profile_code = power_profile_one;
    next_ctl.low_power_mode = power_profile_one == AMCR_PWR_LOW;
    next_ctl.timestamp_input_enable =
      timestamp_input_control[AMCR_TS_EN_BIT];
    next_ctl.timestamp_input_pecl_mode =
      timestamp_input_control[AMCR_TS_PECL_BIT];
    next_ctl.ref_clock_output =
      ref_clock_output_control[AMCR_REFO_EN_BIT] && synth_enable;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ctl <= '0;
    else
      ctl <= next_ctl;
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  property p_refo;
    @(posedge clk_sys) disable iff (!rstn)
    ctl.ref_clock_output |-> $past(synth_enable) &&
      $past(ref_clock_output_control[AMCR_REFO_EN_BIT]);
  endproperty
  a_refo: assert property (p_refo) else $error("ref out no enable");

  property p_pos_ro;
    @(posedge clk_sys) disable iff (!rstn)
    !pos_capture |=> $stable(sync_edge_position);
  endproperty
  a_pos_ro: assert property (p_pos_ro) else $error("position moved");

  property p_pos_cap;
    @(posedge clk_sys) disable iff (!rstn)
    pos_capture |=> sync_edge_position == $past(pos_value);
  endproperty
  a_pos_cap: assert property (p_pos_cap) else $error("capture lost");

  property p_fs;
    @(posedge clk_sys) disable iff (!rstn)
    wr_fs1 |=> ##1 ctl.full_scale_trim[15:8] == $past(req.wdata, 2);
  endproperty
  a_fs: assert property (p_fs) else $error("trim not applied");

  property p_sel;
    @(posedge clk_sys) disable iff (!rstn)
    wr_sel |=> ##1 ctl.sync_delay_select == $past(req.wdata[3:0], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("select not applied");

  property p_ts;
    @(posedge clk_sys) disable iff (!rstn)
    wr_ts |=> ##1 ctl.timestamp_input_enable == $past(req.wdata[0], 2);
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp enable wrong");

  property p_low;
    @(posedge clk_sys) disable iff (!rstn)
    wr_pwr && req.wdata == AMCR_PWR_LOW |=> ##1 ctl.low_power_mode;
  endproperty
  a_low: assert property (p_low) else $error("low power not set");

  property p_rst;
    @(posedge clk_sys)
    !rstn |=> full_scale_trim == AMCR_FS_RST &&
      ref_clock_output_control == AMCR_REFO_RST &&
      power_profile_one == AMCR_PWR_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");

  property p_rd;
    @(posedge clk_sys) disable iff (!rstn)
    req.rd && req.addr == AMCR_PWR_ADDR && !wr_pwr |=>
      rvalid && rdata == power_profile_one;
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");

  property p_refo_off;
    @(posedge clk_sys) disable iff (!rstn)
    !synth_enable |=> !ctl.ref_clock_output;
  endproperty
  a_refo_off: assert property (p_refo_off) else $error("ref out on");

  property p_pecl;
    @(posedge clk_sys) disable iff (!rstn)
    wr_ts |=> ##1 ctl.timestamp_input_pecl_mode == $past(req.wdata[1], 2);
  endproperty
  a_pecl: assert property (p_pecl) else $error("pecl mode wrong");

  // Read data must stay quiet between answers, so a stale byte is never
  // mistaken for an answer by a port that ignores the valid flag.
  property p_idle;
    @(posedge clk_sys) disable iff (!rstn)
    !rvalid |-> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");

  c_cap: cover property (@(posedge clk_sys) disable iff (!rstn) pos_capture);
  c_refo: cover property (@(posedge clk_sys) disable iff (!rstn)
    ctl.ref_clock_output);
  c_low: cover property (@(posedge clk_sys) disable iff (!rstn)
    ctl.low_power_mode);
  c_rd: cover property (@(posedge clk_sys) disable iff (!rstn) rvalid);
  c_pos_wr: cover property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == AMCR_POS_ADDR1);

endmodule : amcr_regs
`default_nettype wire

// ===== verif/amcr_host.sv
/*
  Host model: issues single byte writes and reads to the register bank.
  Assumes the bank takes a strobe on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module amcr_host
(
  // Clock.
  input wire logic clk_sys,
  // Register access.
  output var amcr_pkg::amcr_req_t req
);
  import amcr_pkg::*;
  initial req = '0;
  // ==========================================================================
  // Byte access
  // ==========================================================================
  // reserved bits from caller
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clk_sys);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_sys);
    req <= '0;
  end
  endtask : put
endmodule : amcr_host
`default_nettype wire

// ===== verif/tb.sv
/*
  Self-checking bench for amcr_regs driven through the host model.
  Assumes amcr_pkg and amcr_host are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import amcr_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic pos_capture = 1'b0;
  logic [23:0] pos_value = 24'h000000;
  logic synth_enable = 1'b1;
  amcr_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  amcr_ctl_t ctl;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int check_count = 0;
  int seed = 43;
  logic [23:0] pos;
  logic [15:0] trim;
  logic [3:0] sel;
  always #5 clk_sys = ~clk_sys;
  amcr_host u_host (.clk_sys(clk_sys), .req(req));
  amcr_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .req(req),
    .rdata(rdata), .rvalid(rvalid), .pos_capture(pos_capture),
    .pos_value(pos_value), .synth_enable(synth_enable), .ctl(ctl));
  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
  begin
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
  begin
    exp_q.push_back(e);
    u_host.put(1'b0, a, 8'h00);
  end
  endtask : rd
  task automatic complete_run;
  begin
    // Any read answer that never arrived counts against the run.
    if (exp_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : complete_run
  always @(negedge clk_sys)
  begin
    // An answer that is unknown or comes unasked also counts.
    if (rvalid !== 1'b0)
    begin
      if (exp_q.size() > 0)
      begin
        check(rvalid, 1'b1);
        check(rdata, exp_q.pop_front());
      end
      else
        check(rvalid, 1'b0);
    end
  end
  initial
  begin
    #100000;
    fail_count++;
    complete_run();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    rd(AMCR_POS_ADDR2, 8'h00);
    rd(AMCR_FS_ADDR0, 8'h00);
    rd(AMCR_FS_ADDR1, 8'hA0);
    rd(AMCR_PWR_ADDR, 8'h4B);
    rd(AMCR_TS_ADDR, 8'h00);
    rd(AMCR_REFO_ADDR, 8'h01);
    rd(8'h40, 8'h00);
    check(ctl.ref_clock_output, 1'b1);
    check(ctl.timestamp_input_enable, 1'b0);
    check(ctl.timestamp_input_pecl_mode, 1'b0);
    $display("test reset values done");
    pos = 24'($random(seed));
    pos_value = pos;
    pos_capture = 1'b1;
    @(negedge clk_sys);
    pos_capture = 1'b0;
    pos_value = ~pos;
    u_host.put(1'b1, AMCR_POS_ADDR1, ~pos[15:8]);
    rd(AMCR_POS_ADDR0, pos[7:0]);
    rd(AMCR_POS_ADDR1, pos[15:8]);
    rd(AMCR_POS_ADDR2, pos[23:16]);
    $display("test edge position done");
    // trim kept above the recommended minimum
    trim = {1'b1, 15'($random(seed))};
    sel = pos[3:0];
    u_host.put(1'b1, AMCR_FS_ADDR0, trim[7:0]);
    u_host.put(1'b1, AMCR_FS_ADDR1, trim[15:8]);
    u_host.put(1'b1, AMCR_SEL_ADDR, {4'h0, sel});
    u_host.put(1'b1, AMCR_PWR_ADDR, 8'h46);
    u_host.put(1'b1, AMCR_TS_ADDR, 8'h03);
    u_host.put(1'b1, AMCR_REFO_ADDR, 8'h00);
    repeat (2) @(negedge clk_sys);
    check(ctl.full_scale_trim, trim);
    check(ctl.sync_delay_select, sel);
    check(ctl.power_profile_code, 8'h46);
    check(ctl.low_power_mode, 1'b1);
    check(ctl.timestamp_input_enable, 1'b1);
    check(ctl.timestamp_input_pecl_mode, 1'b1);
    check(ctl.ref_clock_output, 1'b0);
    rd(AMCR_FS_ADDR1, trim[15:8]);
    rd(AMCR_SEL_ADDR, {4'h0, sel});
    $display("test control writes done");
    u_host.put(1'b1, AMCR_REFO_ADDR, 8'h01);
    u_host.put(1'b1, AMCR_PWR_ADDR, 8'h4B);
    synth_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(ctl.ref_clock_output, 1'b0);
    check(ctl.low_power_mode, 1'b0);
    synth_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(ctl.ref_clock_output, 1'b1);
    $display("test reference output done");
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    rd(AMCR_FS_ADDR1, 8'hA0);
    rd(AMCR_TS_ADDR, 8'h00);
    rd(AMCR_SEL_ADDR, 8'h00);
    rd(AMCR_POS_ADDR0, 8'h00);
    check(ctl.timestamp_input_enable, 1'b0);
    check(ctl.ref_clock_output, 1'b1);
    $display("test mid-run reset done");
    repeat (3) @(negedge clk_sys);
    complete_run();
  end
endmodule : tb
`default_nettype wire
